//--- hdl/led_boost_current_controller.sv
`timescale 1ns/100ps
// Purpose: switch sequencing, soft-start and enable/pwm control of a boost led driver
// Assumes: ctrl_in synchronous to ref_clk; comparator levels asynchronous
// Notes: long qualification counts are parameters so simulation can shorten them
// Contract
// - Switch on when feedback falls below the reference and nothing blocks it.
// - Switch off as soon as the inductor current reaches the peak limit.
// - Force the switch off when its on-time reaches the maximum on-time.
// - Keep the switch off until both the least off-time passed and feedback is low again.
// - Soft-start runs a quarter limit for 256 cycles, then half for 256, then full.
// - Enable only after the control input was high continuously for the enable time.
// - Every disabled-to-enabled step starts with soft-start.
// - Shut down when the input stays low for the shutdown time and open the return switch.
// - While enabled the return switch follows the control input level.
// - Close the return switch at once on a rising input and blank the comparator for a while.
// - Also shut down when a low phase of the input exceeds the low-duty off-time.
// - Hold the switch off while the output is above the overvoltage threshold.
// - Under undervoltage keep both switches open and the device off.
// - On over-temperature keep both switches open and the device off.
module led_boost_current_controller
  import led_boost_pkg::*;
#(
  parameter int unsigned ENABLE_QUAL = ENABLE_QUAL_CYC,
  parameter int unsigned SHUTDOWN_QUAL = SHUTDOWN_QUAL_CYC,
  parameter int unsigned LOW_DUTY_OFF = LOW_DUTY_OFF_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host control pin
  input wire logic ctrl_in,
  // analog comparators
  input wire logic current_sense_feedback_low,
  input wire logic switch_current_limit_hit,
  input wire logic overvoltage_sense,
  input wire logic uvlo_active,
  input wire logic thermal_shutdown,
  // power stage
  output logic main_power_switch,
  output logic led_return_switch,
  output logic [1:0] switch_current_limit,
  output logic device_enabled
);
  import led_boost_pkg::*;

  logic [3:0] cmp_sync;
  logic below_ref;
  logic peak_hit;
  logic over_volt;
  logic fault;

  // every comparator except the thermal flag is resynchronised before use
  level_sync #(.WIDTH(4)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({current_sense_feedback_low, switch_current_limit_hit, overvoltage_sense,
               uvlo_active}),
    .sync_out(cmp_sync)
  );
  assign below_ref = cmp_sync[3];
  assign peak_hit = cmp_sync[2];
  assign over_volt = cmp_sync[1];
  // thermal flag is already a digital level from the sensor block
  assign fault = cmp_sync[0] | thermal_shutdown;

  // enable / shutdown qualification
  logic enabled_r, enabled_nxt;
  logic [QUAL_W-1:0] high_cnt_r, high_cnt_nxt;
  logic [QUAL_W-1:0] low_cnt_r, low_cnt_nxt;
  logic ctrl_d_r, ctrl_d_nxt;
  logic start_soft;

  always_comb begin
    enabled_nxt = enabled_r;
    high_cnt_nxt = high_cnt_r;
    low_cnt_nxt = low_cnt_r;
    ctrl_d_nxt = ctrl_in;
    start_soft = 1'b0;
    if (ctrl_in) begin
      low_cnt_nxt = '0;
      if (high_cnt_r < QUAL_W'(ENABLE_QUAL))
        high_cnt_nxt = high_cnt_r + 1'b1;
    end else begin
      high_cnt_nxt = '0;
      if (low_cnt_r < QUAL_W'(SHUTDOWN_QUAL))
        low_cnt_nxt = low_cnt_r + 1'b1;
    end
    if (fault) begin
      enabled_nxt = 1'b0;
    end else if (!enabled_r) begin
      if (ctrl_in && high_cnt_r + 1'b1 >= QUAL_W'(ENABLE_QUAL)) begin
        enabled_nxt = 1'b1;
        start_soft = 1'b1;
      end
    end else if (!ctrl_in) begin
      // the shorter low-duty limit trips first; both remain in force
      if (low_cnt_r + 1'b1 >= QUAL_W'(SHUTDOWN_QUAL))
        enabled_nxt = 1'b0;
      if (low_cnt_r + 1'b1 >= QUAL_W'(LOW_DUTY_OFF))
        enabled_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enabled_r <= 1'b0;
      high_cnt_r <= '0;
      low_cnt_r <= '0;
      ctrl_d_r <= 1'b0;
    end else begin
      enabled_r <= enabled_nxt;
      high_cnt_r <= high_cnt_nxt;
      low_cnt_r <= low_cnt_nxt;
      ctrl_d_r <= ctrl_d_nxt;
    end
  end

  // return switch and comparator blanking
  logic ret_r, ret_nxt;
  logic [PULSE_W-1:0] blank_r, blank_nxt;

  always_comb begin
    ret_nxt = 1'b0;
    blank_nxt = blank_r;
    if (enabled_nxt && !fault)
      ret_nxt = ctrl_in;
    if (ctrl_in && !ctrl_d_r)
      blank_nxt = PULSE_W'(BLANK_CYC);
    else if (blank_r != '0)
      blank_nxt = blank_r - 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ret_r <= 1'b0;
      blank_r <= '0;
    end else begin
      ret_r <= ret_nxt;
      blank_r <= blank_nxt;
    end
  end

  // main switch sequencing
  sw_state_e sw_r, sw_nxt;
  logic [PULSE_W-1:0] tmr_r, tmr_nxt;
  logic [SOFT_W:0] soft_r, soft_nxt;
  logic [1:0] lim_nxt;
  logic run;

  // the switch only runs while the leds draw current; otherwise feedback stays low forever
  assign run = enabled_r && ret_r && !fault;

  always_comb begin
    sw_nxt = sw_r;
    tmr_nxt = tmr_r;
    soft_nxt = soft_r;
    case (sw_r)
      SW_IDLE: begin
        tmr_nxt = '0;
        if (run && below_ref && !over_volt && blank_r == '0) begin
          sw_nxt = SW_ON;
          tmr_nxt = '0;
        end
      end
      SW_ON: begin
        tmr_nxt = tmr_r + 1'b1;
        // peak current or the on-time ceiling both end the pulse
        if (!run || over_volt || peak_hit ||
            tmr_r + 1'b1 >= PULSE_W'(MAX_ON_CYC)) begin
          sw_nxt = SW_OFF;
          tmr_nxt = '0;
          if (soft_r < (SOFT_W + 1)'(2 * SOFT_STEP_CYCLES))
            soft_nxt = soft_r + 1'b1;
        end
      end
      SW_OFF: begin
        if (tmr_r < PULSE_W'(MIN_OFF_CYC))
          tmr_nxt = tmr_r + 1'b1;
        if (tmr_r + 1'b1 >= PULSE_W'(MIN_OFF_CYC))
          sw_nxt = SW_IDLE;
      end
      default: begin
        sw_nxt = SW_IDLE;
        tmr_nxt = '0;
      end
    endcase
    if (start_soft || !enabled_r)
      soft_nxt = '0;
    if (soft_nxt < (SOFT_W + 1)'(SOFT_STEP_CYCLES))
      lim_nxt = LIMIT_QUARTER;
    else if (soft_nxt < (SOFT_W + 1)'(2 * SOFT_STEP_CYCLES))
      lim_nxt = LIMIT_HALF;
    else
      lim_nxt = LIMIT_FULL;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sw_r <= SW_IDLE;
      tmr_r <= '0;
      soft_r <= '0;
    end else begin
      sw_r <= sw_nxt;
      tmr_r <= tmr_nxt;
      soft_r <= soft_nxt;
    end
  end

  // outputs straight from flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      main_power_switch <= 1'b0;
      led_return_switch <= 1'b0;
      switch_current_limit <= LIMIT_QUARTER;
      device_enabled <= 1'b0;
    end else begin
      main_power_switch <= (sw_nxt == SW_ON) && !fault;
      led_return_switch <= ret_nxt;
      switch_current_limit <= lim_nxt;
      device_enabled <= enabled_nxt;
    end
  end
endmodule

//--- hdl/led_boost_pkg.sv
// Purpose: constants for the led boost current controller
// Assumes: 40 MHz ref_clk, all analog comparator outputs arrive as digital levels
// Notes: times are held in their own unit and converted to cycles here
package led_boost_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_PS = 1_000_000_000 / (CLK_HZ / 1000);
  // analog thresholds, for reference only; the comparators sit outside
  localparam int unsigned FEEDBACK_REF_MV = 252;
  localparam int unsigned SWITCH_LIMIT_MA = 400;
  localparam int unsigned OVERVOLT_LIMIT_MV = 19_000;
  localparam int unsigned UVLO_THRESHOLD_MV = 1_500;
  localparam int unsigned THERMAL_LIMIT_DEGC = 160;
  localparam int unsigned PWM_MIN_HZ = 100;
  localparam int unsigned PWM_MAX_HZ = 50_000;
  // longest on-time 4.5 us, rounded down
  localparam int unsigned MAX_ON_NS = 4500;
  localparam int unsigned MAX_ON_CYC = (MAX_ON_NS * 1000) / CLK_PERIOD_PS;
  // least off-time, rounded up
  localparam int unsigned MIN_OFF_NS = 400;
  localparam int unsigned MIN_OFF_CYC = (MIN_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // comparator blanking after the return switch closes
  localparam int unsigned BLANK_NS = 400;
  localparam int unsigned BLANK_CYC = (BLANK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // qualification times; defaults of the top-level parameters
  localparam int unsigned ENABLE_QUAL_US = 500;
  localparam int unsigned ENABLE_QUAL_CYC = ENABLE_QUAL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SHUTDOWN_QUAL_MS = 32;
  localparam int unsigned SHUTDOWN_QUAL_CYC = SHUTDOWN_QUAL_MS * (CLK_HZ / 1000);
  localparam int unsigned LOW_DUTY_OFF_MS = 10;
  localparam int unsigned LOW_DUTY_OFF_CYC = LOW_DUTY_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned QUAL_W = 22;
  localparam int unsigned PULSE_W = 8;
  // soft-start: switch cycles spent at each reduced limit
  localparam int unsigned SOFT_STEP_CYCLES = 256;
  localparam int unsigned SOFT_W = 9;
  // limit selector driven to the current-limit DAC
  localparam logic [1:0] LIMIT_QUARTER = 2'h0;
  localparam logic [1:0] LIMIT_HALF = 2'h1;
  localparam logic [1:0] LIMIT_FULL = 2'h2;
  typedef enum logic [1:0] {SW_IDLE, SW_ON, SW_OFF} sw_state_e;
endpackage

//--- hdl/level_sync.sv
`timescale 1ns/100ps
// Purpose: two-flop synchroniser for a bundle of comparator levels
// Assumes: inputs are slow levels from analog comparators
// Notes: first stage feeds only the second stage
module level_sync #(
  parameter int unsigned WIDTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_r[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_r[i] <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

//--- sim/host_ctrl_model.sv
`timescale 1ns/100ps
// Purpose: host that drives the combined enable and pwm pin
// Assumes: levels change right after a rising edge
// Notes: pwm phases can be shorter than a switch cycle
module host_ctrl_model (
  // clock
  input wire logic ref_clk,
  // control pin
  output logic ctrl_in
);
  initial ctrl_in = 1'b0;
  // level stands for n samples; long highs enable, long lows shut down
  task automatic hold(input logic lvl, input int n);
    @(posedge ref_clk);
    ctrl_in <= lvl;
    repeat (n - 1) @(posedge ref_clk);
  endtask
endmodule

//--- sim/led_boost_checker.sv
`timescale 1ns/100ps
// Purpose: port checks of the led boost current controller
// Assumes: sees the top ports only; spans follow the package
// Notes: long on and off spans are counted in helper logic
module led_boost_checker
  import led_boost_pkg::*;
#(
  parameter int unsigned ENABLE_QUAL = 20,
  parameter int unsigned SHUTDOWN_QUAL = 200,
  parameter int unsigned LOW_DUTY_OFF = 100
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // inputs
  input wire logic ctrl_in,
  input wire logic current_sense_feedback_low,
  input wire logic switch_current_limit_hit,
  input wire logic overvoltage_sense,
  input wire logic uvlo_active,
  input wire logic thermal_shutdown,
  // outputs
  input wire logic main_power_switch,
  input wire logic led_return_switch,
  input wire logic [1:0] switch_current_limit,
  input wire logic device_enabled
);
  logic [8:0] on_cnt_r, on_cnt_nxt;
  logic [4:0] off_cnt_r, off_cnt_nxt;
  logic [QUAL_W-1:0] hi_cnt_r, hi_cnt_nxt;
  logic [QUAL_W-1:0] lo_cnt_r, lo_cnt_nxt;
  always_comb begin
    on_cnt_nxt = main_power_switch ? on_cnt_r + 9'h1 : 9'h0;
    off_cnt_nxt = main_power_switch ? 5'h0 : off_cnt_r + 5'(off_cnt_r != 5'h1f);
    hi_cnt_nxt = '0;
    lo_cnt_nxt = '0;
    // consecutive samples of each control level, saturating
    if (ctrl_in)
      hi_cnt_nxt = hi_cnt_r + QUAL_W'(hi_cnt_r != '1);
    else
      lo_cnt_nxt = lo_cnt_r + QUAL_W'(lo_cnt_r != '1);
  end
  // off count starts saturated so the first turn-on after reset is legal
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      on_cnt_r <= 9'h0;
      off_cnt_r <= 5'h1f;
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
    end else begin
      on_cnt_r <= on_cnt_nxt;
      off_cnt_r <= off_cnt_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      lo_cnt_r <= lo_cnt_nxt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  thermal_open_a: assert property (thermal_shutdown |=>
    !main_power_switch && !led_return_switch)
    else $error("switch closed in thermal shutdown");
  uvlo_open_a: assert property (uvlo_active [*4] |->
    !main_power_switch && !led_return_switch)
    else $error("switch closed under undervoltage");
  overvolt_off_a: assert property (overvoltage_sense [*4] |-> !main_power_switch)
    else $error("main switch closed above overvoltage");
  peak_off_a: assert property (switch_current_limit_hit [*4] |-> !main_power_switch)
    else $error("main switch closed at current limit");
  max_on_a: assert property (on_cnt_r <= MAX_ON_CYC)
    else $error("main switch on beyond maximum on-time");
  min_off_a: assert property ($rose(main_power_switch) |-> off_cnt_r >= MIN_OFF_CYC)
    else $error("main switch off-time too short");
  return_follow_a: assert property (device_enabled && $past(device_enabled) |->
    led_return_switch == $past(ctrl_in)) else $error("return switch not following control");
  disabled_open_a: assert property (!device_enabled |->
    !led_return_switch && !main_power_switch)
    else $error("switch closed while disabled");
  soft_start_a: assert property ($rose(device_enabled) |->
    switch_current_limit == LIMIT_QUARTER)
    else $error("enable did not start at quarter limit");
  enable_qual_a: assert property ($rose(device_enabled) |->
    hi_cnt_r >= QUAL_W'(ENABLE_QUAL))
    else $error("enabled before the control input qualified");
  low_duty_off_a: assert property (lo_cnt_r >= QUAL_W'(LOW_DUTY_OFF) |->
    !device_enabled)
    else $error("still enabled after the low-duty off-time");
  shutdown_qual_a: assert property (lo_cnt_r >= QUAL_W'(SHUTDOWN_QUAL) |->
    !device_enabled)
    else $error("still enabled after the shutdown time");
endmodule
bind led_boost_current_controller led_boost_checker #(.ENABLE_QUAL(ENABLE_QUAL),
  .SHUTDOWN_QUAL(SHUTDOWN_QUAL), .LOW_DUTY_OFF(LOW_DUTY_OFF)) i_checker (.ref_clk(ref_clk),
  .rst(rst), .ctrl_in(ctrl_in), .current_sense_feedback_low(current_sense_feedback_low),
  .switch_current_limit_hit(switch_current_limit_hit), .overvoltage_sense(overvoltage_sense),
  .uvlo_active(uvlo_active), .thermal_shutdown(thermal_shutdown),
  .main_power_switch(main_power_switch), .led_return_switch(led_return_switch),
  .switch_current_limit(switch_current_limit), .device_enabled(device_enabled));

//--- sim/led_boost_current_controller_tb.sv
`timescale 1ns/100ps
// Purpose: self-checking bench of the led boost current controller
// Assumes: qualification counts shortened to 20, 200 and 100 cycles
// Notes: each scenario drives and judges by itself
module led_boost_current_controller_tb;
  import led_boost_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, below_ref = 1'b0, hit = 1'b0;
  logic over_volt = 1'b0, uvlo = 1'b0, hot = 1'b0;
  logic ctrl_in, main_power_switch, led_return_switch, device_enabled;
  logic [1:0] switch_current_limit;
  int miscompares = 0, num_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  host_ctrl_model i_host (.ref_clk(ref_clk), .ctrl_in(ctrl_in));
  led_boost_current_controller #(.ENABLE_QUAL(20), .SHUTDOWN_QUAL(200), .LOW_DUTY_OFF(100)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .ctrl_in(ctrl_in), .current_sense_feedback_low(below_ref),
    .switch_current_limit_hit(hit), .overvoltage_sense(over_volt), .uvlo_active(uvlo),
    .thermal_shutdown(hot), .main_power_switch(main_power_switch),
    .led_return_switch(led_return_switch), .switch_current_limit(switch_current_limit),
    .device_enabled(device_enabled));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_main(input logic v, input int n);
    // look just after each edge so the output is settled
    for (int i = 0; i < n && main_power_switch !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic pulse();
    wait_main(1'b1, 60);
    chk(4'(main_power_switch), 4'h1);
    @(posedge ref_clk) hit <= 1'b1;
    tick(4);
    chk(4'(main_power_switch), 4'h0);
    @(posedge ref_clk) hit <= 1'b0;
    tick(2);
  endtask
  task automatic t_enable();
    i_host.hold(1'b1, 19);
    i_host.hold(1'b0, 3);
    tick(1);
    chk(4'(device_enabled), 4'h0);
    i_host.hold(1'b1, 25);
    tick(1);
    chk(4'({device_enabled, led_return_switch}), 4'h3);
    chk(4'(switch_current_limit), 4'(LIMIT_QUARTER));
    $display("test enable done");
  endtask
  task automatic t_soft();
    @(posedge ref_clk) below_ref <= 1'b1;
    for (int i = 0; i < 512; i++) begin
      pulse();
      if (i == 254) chk(4'(switch_current_limit), 4'(LIMIT_QUARTER));
      if (i == 255) chk(4'(switch_current_limit), 4'(LIMIT_HALF));
      if (i == 511) chk(4'(switch_current_limit), 4'(LIMIT_FULL));
    end
    $display("test soft start done");
  endtask
  task automatic t_maxon();
    int n;
    n = 0;
    wait_main(1'b1, 60);
    while (main_power_switch === 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(4'(n == MAX_ON_CYC), 4'h1);
    @(posedge ref_clk) over_volt <= 1'b1;
    tick(40);
    chk(4'(main_power_switch), 4'h0);
    @(posedge ref_clk) over_volt <= 1'b0;
    wait_main(1'b1, 60);
    chk(4'(main_power_switch), 4'h1);
    $display("test on-time and overvoltage done");
  endtask
  task automatic t_pwm();
    i_host.hold(1'b0, 50);
    tick(1);
    chk(4'({device_enabled, led_return_switch}), 4'h2);
    i_host.hold(1'b1, 5);
    tick(1);
    chk(4'({led_return_switch, main_power_switch}), 4'h2);
    i_host.hold(1'b0, 110);
    tick(1);
    chk(4'({device_enabled, led_return_switch}), 4'h0);
    // stay low past the longer shutdown time as well
    i_host.hold(1'b0, 100);
    tick(1);
    chk(4'({device_enabled, led_return_switch}), 4'h0);
    $display("test pwm done");
  endtask
  task automatic t_fault();
    i_host.hold(1'b1, 25);
    @(posedge ref_clk) hot <= 1'b1;
    tick(2);
    chk(4'({main_power_switch, led_return_switch, device_enabled}), 4'h0);
    @(posedge ref_clk) hot <= 1'b0;
    i_host.hold(1'b0, 3);
    i_host.hold(1'b1, 25);
    tick(1);
    chk(4'({device_enabled, switch_current_limit}), 4'h4);
    @(posedge ref_clk) uvlo <= 1'b1;
    tick(5);
    chk(4'({main_power_switch, led_return_switch, device_enabled}), 4'h0);
    @(posedge ref_clk) uvlo <= 1'b0;
    $display("test faults done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_enable();
    t_soft();
    t_maxon();
    t_pwm();
    t_fault();
    final_report();
  end
  // about 12k cycles expected; over six times that means a hang
  initial begin
    #2000000;
    miscompares++;
    final_report();
  end
endmodule
